// ===== rplc_pkg.sv
// Shared constants and types for the reset, power-mode and flash lock controller.
// Assumes one system clock and an APB register port of 32-bit words.
package rplc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] RPLC_POWER_CONTROL_REG_OFS   = 8'h00; // power_control_reg
  localparam logic [7:0] RPLC_FCFG_OFS   = 8'h04; // flash_config_reg
  localparam logic [7:0] RPLC_MBOX_OFS   = 8'h08; // flash_command_mailbox
  localparam logic [7:0] RPLC_STAT_OFS   = 8'h0c; // status

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RPLC_IDLE_BIT      = 0;  // idle_request_bit
  localparam int RPLC_PD_BIT        = 1;  // power_down_bit
  localparam int RPLC_LOCK_LSB      = 5;  // lock decode [6:5]
  localparam int RPLC_LOCK_MSB      = 6;
  localparam int RPLC_BLK_BIT       = 8;  // flash_block_select in mailbox
  localparam int RPLC_ST_REFUSE_BIT = 4;
  localparam int RPLC_ST_ACCEPT_BIT = 5;
  localparam int RPLC_ST_SUPPLY_BIT = 6;
  localparam int RPLC_ST_EA_BIT     = 7;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [1:0]  RPLC_CFG_RST      = 2'h0;  // writable config bits
  localparam logic [1:0]  RPLC_LOCK_RST     = 2'h3;  // safest until captured
  localparam logic [15:0] RPLC_RESET_VECTOR = 16'h0000;
  localparam logic [4:0]  RPLC_RST_HOLD_CLKS = 5'h18; // 24 high samples
  localparam int          RPLC_SYNC_N       = 4;

  // Lock decode values
  localparam logic [1:0] RPLC_LOCK_NONE = 2'h0;
  localparam logic [1:0] RPLC_LOCK_BLK1 = 2'h1;
  localparam logic [1:0] RPLC_LOCK_SOFT = 2'h2;
  localparam logic [1:0] RPLC_LOCK_HARD = 2'h3;
  localparam logic [3:0] RPLC_SEC_NONE  = 4'hf;
  localparam logic [3:0] RPLC_SEC_BLK1  = 4'h3;
  localparam logic [3:0] RPLC_SEC_SOFT  = 4'h5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    RPLC_CMD_NONE   = 4'h0,
    RPLC_CMD_CHIPER = 4'h1,
    RPLC_CMD_BLKER  = 4'h2,
    RPLC_CMD_SECER  = 4'h3,
    RPLC_CMD_BYTEPG = 4'h4,
    RPLC_CMD_BURST  = 4'h5,
    RPLC_CMD_VERIFY = 4'h6
  } rplc_cmd_t;

  typedef enum logic [2:0] {
    RPLC_RUN   = 3'b001,
    RPLC_IDLE  = 3'b010,
    RPLC_PDOWN = 3'b100
  } rplc_pmode_t;

  // Flash command handed on to the flash controller
  typedef struct packed {
    rplc_cmd_t code;
    logic      blk;   // flash_block_select: 1 = secondary block
  } rplc_fcmd_t;

  // Bus strobe pins
  typedef struct packed {
    logic ale;
    logic program_store_strobe_n;
  } rplc_strobe_t;

  // Clock gates
  typedef struct packed {
    logic cpu;
    logic periph;   // timers and serial port
    logic intr;     // internal interrupt logic
  } rplc_clkgate_t;

endpackage

// ===== rplc_ctrl.sv
// Reset sequencer, power-mode control and flash security lock gate.
// Assumes APB software access, pins arriving asynchronously, and a
// flash controller that executes the commands passed on to it.
// Operation
// R01 - Decode security nibble into two lock bits
// R02 - Soft lock refuses commands from external code
// R03 - Lock decode bits are read only
// R04 - Lock bits load only on reset exit
// R05 - Chip erase completion clears lock bits
// R06 - Soft lock allows internal-code commands both blocks
// R07 - Soft lock lets each block program other
// R08 - Hard lock refuses all erase/program/verify
// R09 - Secondary lock allows primary block only
// R10 - Chip erase always allowed, removes lock
// R11 - New lock code applies after next reset
// R12 - External programmer refused on locked block
// R13 - Fetch restarts at address zero after reset
// R14 - Reset pin held 24 clocks by outside
// R15 - Strobes weakly high during reset
// R16 - Reset restores registers, keeps data RAM
// R17 - Power-up writes ones to port latches
// R18 - Invalid supply blocks flash erase/program
// R19 - Idle gates CPU clock, strobes high
// R20 - Idle ends on interrupt or reset
// R21 - Power-down gates all clocks, strobes low
// R22 - Power-down ends on external interrupt or reset
// R23 - Outside stops clock glitch-free
// R24 - Stop clock keeps state, resumes next clock
// R25 - Reset asserts after 24 synchronised high samples
// R26 - Idle plus power-down together enters power-down
`timescale 1ns/100ps
module rplc_ctrl (
  // Clock, reset, clock enable
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   ce,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  // Asynchronous pins
  input  wire logic                   reset_pin,
  input  wire logic                   external_access_n,
  input  wire logic                   ext_int_n,
  input  wire logic                   supply_ok,
  // Same-clock inputs
  input  wire logic                   host_mode,
  input  wire logic [7:0]             security_byte,
  input  wire logic                   chip_erase_done,
  input  wire logic                   irq_service_start,
  input  wire rplc_pkg::rplc_strobe_t cpu_strobe,
  // Outputs to core, flash and pins
  output rplc_pkg::rplc_strobe_t      strobe_out,
  output logic                        strobe_weak,
  output rplc_pkg::rplc_clkgate_t     clk_gate,
  output logic                        sys_reset,
  output logic [15:0]                 fetch_addr,
  output logic                        port_latch_ones,
  output logic                        flash_cmd_valid,
  output rplc_pkg::rplc_fcmd_t        flash_cmd
);
  import rplc_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [RPLC_SYNC_N-1:0] pin_raw;    // Raw pin levels
  logic [RPLC_SYNC_N-1:0] sync1_q;    // First stage, read by stage two only
  logic [RPLC_SYNC_N-1:0] sync2_q;    // Safe to use
  logic                   rst_s;      // Synchronised reset pin
  logic                   ea_n_s;     // Synchronised external access
  logic                   eint_n_s;   // Synchronised external interrupt
  logic                   supply_s;   // Synchronised supply valid

  assign pin_raw  = {supply_ok, ext_int_n, external_access_n, reset_pin};
  assign rst_s    = sync2_q[0];
  assign ea_n_s   = sync2_q[1];
  assign eint_n_s = sync2_q[2];
  assign supply_s = sync2_q[3];

  // Two flops per pin; the frozen clock enable also freezes them
  genvar gi;
  generate
    for (gi = 0; gi < RPLC_SYNC_N; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else if (ce) begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  logic [4:0] hold_cnt_q, hold_cnt_d;   // Consecutive high samples
  logic       sys_rst_q, sys_rst_d;     // Internal system reset
  logic       por_q, por_d;             // First cycle after power-up
  logic       rst_release;              // Last cycle of internal reset

  // Counting filters short glitches on the pin; outside must hold 24 clocks
  always_comb begin
    hold_cnt_d = hold_cnt_q;
    sys_rst_d  = sys_rst_q;
    por_d      = 1'b0;
    if (!rst_s) begin
      hold_cnt_d = 5'h00;
      sys_rst_d  = 1'b0;
    end else if (hold_cnt_q != RPLC_RST_HOLD_CLKS) begin
      hold_cnt_d = hold_cnt_q + 5'h01;
      // Asserted once the 24th high sample is seen, see R25, R14
      sys_rst_d  = (hold_cnt_q + 5'h01) == RPLC_RST_HOLD_CLKS;
    end
  end

  assign rst_release = (sys_rst_q || por_q) && !sys_rst_d;

  // Internal reset starts asserted so every register begins defined
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt_q <= 5'h00;
      sys_rst_q  <= 1'b1;
      por_q      <= 1'b1;
    end else if (ce) begin
      hold_cnt_q <= hold_cnt_d;
      sys_rst_q  <= sys_rst_d;
      por_q      <= por_d;
    end
  end

  // ----------------------------------------------------------------
  // Lock decode
  // ----------------------------------------------------------------
  logic [1:0] lock_q, lock_d;   // Read-only decode bits
  logic [1:0] sec_decode;       // Decode of security nibble

  // Three codes map to three lock levels, any other code to hard lock, see R01
  always_comb begin
    unique case (security_byte[3:0])
      RPLC_SEC_NONE: sec_decode = RPLC_LOCK_NONE;
      RPLC_SEC_BLK1: sec_decode = RPLC_LOCK_BLK1;
      RPLC_SEC_SOFT: sec_decode = RPLC_LOCK_SOFT;
      default:       sec_decode = RPLC_LOCK_HARD;
    endcase
  end

  // Capture at reset exit only; software writes never reach it
  always_comb begin
    lock_d = lock_q;
    if (rst_release) begin
      lock_d = sec_decode;               // see R04, R11
    end else if (chip_erase_done) begin
      lock_d = RPLC_LOCK_NONE;           // see R05, R10
    end
  end

  // Lock survives internal reset: only the release reloads it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q <= RPLC_LOCK_RST;
    end else if (ce) begin
      lock_q <= lock_d;
    end
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic apb_wr;      // Write completing this cycle
  logic apb_rd;      // Read completing this cycle
  logic hit;         // Address maps to a register

  assign hit = (paddr == RPLC_POWER_CONTROL_REG_OFS) || (paddr == RPLC_FCFG_OFS) ||
               (paddr == RPLC_MBOX_OFS) || (paddr == RPLC_STAT_OFS);
  // Answers in the access cycle unless the clock is frozen
  assign pready  = ce;
  assign pslverr = psel && penable && !hit;
  assign apb_wr  = psel && penable && ce && pwrite && hit && !sys_rst_q;
  assign apb_rd  = psel && penable && ce && !pwrite;

  // ----------------------------------------------------------------
  // Power modes
  // ----------------------------------------------------------------
  rplc_pmode_t pmode_q, pmode_d;   // Current power mode
  logic        power_control_reg_wr;            // Write to power_control_reg

  assign power_control_reg_wr = apb_wr && (paddr == RPLC_POWER_CONTROL_REG_OFS);

  // Mode follows the software bits and leaves on wake events
  always_comb begin
    pmode_d = pmode_q;
    unique case (pmode_q)
      RPLC_RUN: begin
        if (power_control_reg_wr && pwdata[RPLC_PD_BIT]) begin
          pmode_d = RPLC_PDOWN;          // see R21, R26
        end else if (power_control_reg_wr && pwdata[RPLC_IDLE_BIT]) begin
          pmode_d = RPLC_IDLE;           // see R19
        end
      end
      RPLC_IDLE: begin
        // Servicing clears the idle bit, see R20
        if (irq_service_start) begin
          pmode_d = RPLC_RUN;
        end
      end
      RPLC_PDOWN: begin
        // Only an external interrupt or a hardware reset wakes it, see R22
        if (!eint_n_s) begin
          pmode_d = RPLC_RUN;
        end
      end
    endcase
    // Hardware reset exits both modes, see R20, R22, R16
    if (sys_rst_q) begin
      pmode_d = RPLC_RUN;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pmode_q <= RPLC_RUN;
    end else if (ce) begin
      pmode_q <= pmode_d;
    end
  end

  // ----------------------------------------------------------------
  // Flash config and mailbox
  // ----------------------------------------------------------------
  logic [1:0]  cfg_q, cfg_d;          // Writable config bits
  rplc_fcmd_t  mbox_q, mbox_d;        // Last command written
  logic        refuse_q, refuse_d;    // Sticky: command refused
  logic        accept_q, accept_d;    // Sticky: command passed on
  logic        go_q, go_d;            // One-cycle command strobe
  logic        mbox_wr;               // Write to mailbox
  logic        stat_wr;               // Write to status
  logic        blk_locked;            // Target block under lock
  logic        allow;                 // Command may proceed
  rplc_cmd_t   new_code;              // Incoming command code
  logic        new_blk;               // Incoming block select

  assign mbox_wr  = apb_wr && (paddr == RPLC_MBOX_OFS);
  assign stat_wr  = apb_wr && (paddr == RPLC_STAT_OFS);
  assign new_code = rplc_cmd_t'(pwdata[3:0]);
  assign new_blk  = pwdata[RPLC_BLK_BIT];

  // Soft lock locks both; secondary lock only block 1
  assign blk_locked = (lock_q == RPLC_LOCK_HARD) ||             // see R08
                      (lock_q == RPLC_LOCK_SOFT) ||
                      ((lock_q == RPLC_LOCK_BLK1) && new_blk);   // see R09

  // Gate each command by lock, code origin and supply
  always_comb begin
    allow = 1'b0;
    unique case (new_code)
      RPLC_CMD_CHIPER: begin
        allow = 1'b1;                    // see R10
      end
      RPLC_CMD_BLKER, RPLC_CMD_SECER, RPLC_CMD_BYTEPG,
      RPLC_CMD_BURST, RPLC_CMD_VERIFY: begin
        // Soft lock opens both blocks to internal self_programming,
        // see R06, R07; external code or the host is kept out, see R02
        allow = !blk_locked ||
                ((lock_q == RPLC_LOCK_SOFT) && !host_mode && ea_n_s);
        // Host commands on a locked block are refused, see R12
      end
      default: begin
        allow = 1'b0;                    // Unknown code
      end
    endcase
    // Supply monitor vetoes everything, see R18
    if (!supply_s) begin
      allow = 1'b0;
    end
  end

  // Config, mailbox and result flags; set wins over write-1 clear
  always_comb begin
    cfg_d    = cfg_q;
    mbox_d   = mbox_q;
    refuse_d = refuse_q;
    accept_d = accept_q;
    go_d     = 1'b0;
    if (apb_wr && (paddr == RPLC_FCFG_OFS)) begin
      cfg_d = pwdata[1:0];               // Lock bits ignored, see R03
    end
    if (stat_wr && pwdata[RPLC_ST_REFUSE_BIT]) begin
      refuse_d = 1'b0;
    end
    if (stat_wr && pwdata[RPLC_ST_ACCEPT_BIT]) begin
      accept_d = 1'b0;
    end
    if (mbox_wr) begin
      mbox_d.code = new_code;
      mbox_d.blk  = new_blk;
      if (allow) begin
        go_d     = 1'b1;
        accept_d = 1'b1;
      end else begin
        refuse_d = 1'b1;
      end
    end
    // Registers return to reset values, see R16
    if (sys_rst_q) begin
      cfg_d    = RPLC_CFG_RST;
      mbox_d   = '0;
      refuse_d = 1'b0;
      accept_d = 1'b0;
      go_d     = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q    <= RPLC_CFG_RST;
      mbox_q   <= '0;
      refuse_q <= 1'b0;
      accept_q <= 1'b0;
      go_q     <= 1'b0;
    end else if (ce) begin
      cfg_q    <= cfg_d;
      mbox_q   <= mbox_d;
      refuse_q <= refuse_d;
      accept_q <= accept_d;
      go_q     <= go_d;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] rdata_q, rdata_d;   // Registered read data

  // Read data is chosen in the access cycle itself
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (paddr)
      RPLC_POWER_CONTROL_REG_OFS: begin
        rdata_d[RPLC_IDLE_BIT] = (pmode_q == RPLC_IDLE);
        rdata_d[RPLC_PD_BIT]   = (pmode_q == RPLC_PDOWN);
      end
      RPLC_FCFG_OFS: begin
        rdata_d[1:0]                        = cfg_q;
        rdata_d[RPLC_LOCK_MSB:RPLC_LOCK_LSB] = lock_q;
      end
      RPLC_MBOX_OFS: begin
        rdata_d[3:0]          = mbox_q.code;
        rdata_d[RPLC_BLK_BIT] = mbox_q.blk;
      end
      RPLC_STAT_OFS: begin
        rdata_d[2:0]                = pmode_q;
        rdata_d[RPLC_ST_REFUSE_BIT] = refuse_q;
        rdata_d[RPLC_ST_ACCEPT_BIT] = accept_q;
        rdata_d[RPLC_ST_SUPPLY_BIT] = supply_s;
        rdata_d[RPLC_ST_EA_BIT]     = ea_n_s;
      end
      default: begin
        rdata_d = 32'h0000_0000;         // Unmapped reads zero
      end
    endcase
  end

  // prdata is combinational from the live state to meet zero-wait APB
  assign prdata = apb_rd ? rdata_d : rdata_q;

  // Hold last read word between transfers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (apb_rd) begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin and core outputs
  // ----------------------------------------------------------------
  rplc_strobe_t  strobe_q, strobe_d;   // Strobe pins
  rplc_clkgate_t gate_q, gate_d;       // Clock gates
  logic          weak_q, weak_d;       // Weak pull-up drive
  logic          ports_q, ports_d;     // Port latches to ones
  logic [15:0]   fetch_q, fetch_d;     // Fetch restart address

  // One process decides every pin level from reset and mode
  always_comb begin
    strobe_d = cpu_strobe;
    gate_d   = '{cpu: 1'b1, periph: 1'b1, intr: 1'b1};
    weak_d   = 1'b0;
    ports_d  = 1'b0;
    fetch_d  = fetch_q;
    if (sys_rst_q || por_q) begin
      strobe_d = '{ale: 1'b1, program_store_strobe_n: 1'b1};
      weak_d   = 1'b1;                   // see R15
      ports_d  = 1'b1;                   // see R17
      fetch_d  = RPLC_RESET_VECTOR;      // see R13
    end else if (pmode_q == RPLC_IDLE) begin
      strobe_d   = '{ale: 1'b1, program_store_strobe_n: 1'b1};
      gate_d.cpu = 1'b0;                 // see R19
    end else if (pmode_q == RPLC_PDOWN) begin
      strobe_d = '{ale: 1'b0, program_store_strobe_n: 1'b0};
      gate_d   = '{cpu: 1'b0, periph: 1'b0, intr: 1'b0};   // see R21
    end
  end

  // ce low is stop-clock: all state holds and resumes next edge, see R24
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_q <= '{ale: 1'b1, program_store_strobe_n: 1'b1};
      gate_q   <= '{cpu: 1'b1, periph: 1'b1, intr: 1'b1};
      weak_q   <= 1'b1;
      ports_q  <= 1'b1;
      fetch_q  <= RPLC_RESET_VECTOR;
    end else if (ce) begin
      strobe_q <= strobe_d;
      gate_q   <= gate_d;
      weak_q   <= weak_d;
      ports_q  <= ports_d;
      fetch_q  <= fetch_d;
    end
  end

  assign strobe_out      = strobe_q;
  assign strobe_weak     = weak_q;
  assign clk_gate        = gate_q;
  assign sys_reset       = sys_rst_q;
  assign fetch_addr      = fetch_q;
  assign port_latch_ones = ports_q;
  assign flash_cmd_valid = go_q;
  assign flash_cmd       = mbox_q;

endmodule

// ===== rplc_ctrl_sva.sv
// Port-level assertions for the reset, power-mode and lock controller.
// Assumes one clock domain and binding onto every rplc_ctrl instance.
`timescale 1ns/100ps
module rplc_ctrl_sva (
  // Clock, reset, enable
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   ce,
  // APB request side
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [7:0]             paddr,
  input wire logic [31:0]            pwdata,
  // Wake and supply inputs
  input wire logic                   irq_service_start,
  input wire logic                   ext_int_n,
  input wire logic                   supply_ok,
  // Outputs watched
  input wire rplc_pkg::rplc_strobe_t  strobe_out,
  input wire logic                   strobe_weak,
  input wire rplc_pkg::rplc_clkgate_t clk_gate,
  input wire logic                   sys_reset,
  input wire logic [15:0]            fetch_addr,
  input wire logic                   port_latch_ones,
  input wire logic                   flash_cmd_valid,
  input wire rplc_pkg::rplc_fcmd_t    flash_cmd
);
  import rplc_pkg::*;
  // Write actually taken: reset fully left, clock running
  wire logic wr = psel && penable && pwrite && ce && !sys_reset && !strobe_weak;
  // ----
  // Properties
  // ----
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_RST_OUTS: assert property (
    sys_reset |=> strobe_weak && port_latch_ones && strobe_out == 2'b11)
    else $error("reset outputs not held");
  AST_FETCH_ZERO: assert property (
    sys_reset |=> fetch_addr == 16'h0000) else $error("fetch not at zero");
  AST_IDLE_GATE: assert property (
    (wr && paddr == 8'h00 && pwdata[1:0] == 2'b01 && clk_gate == 3'b111) ##1 ce
    |=> clk_gate == 3'b011 && strobe_out == 2'b11) else $error("idle entry wrong");
  AST_IDLE_EXIT: assert property (
    (clk_gate == 3'b011 && irq_service_start && ce && !sys_reset) ##1 ce
    |=> clk_gate == 3'b111) else $error("idle exit wrong");
  AST_PD_GATE: assert property (
    (wr && paddr == 8'h00 && pwdata[1] && clk_gate == 3'b111) ##1 ce
    |=> clk_gate == 3'b000 && strobe_out == 2'b00) else $error("pd entry wrong");
  AST_PD_WAKE: assert property (
    (clk_gate != 3'b011 && !ext_int_n && ce && !sys_reset) [*5]
    |=> clk_gate == 3'b111) else $error("pd wake wrong");
  AST_SUPPLY_VETO: assert property (
    (!supply_ok && ce) [*4] |=> !flash_cmd_valid) else $error("cmd on bad supply");
  AST_CMD_PASS: assert property (
    wr && paddr == 8'h08 |=> flash_cmd == {$past(pwdata[3:0]), $past(pwdata[8])})
    else $error("mailbox not passed on");
  AST_STOP_HOLD: assert property (
    !ce |=> $stable(clk_gate) && $stable(fetch_addr) && $stable(flash_cmd))
    else $error("state moved while stopped");
endmodule

bind rplc_ctrl rplc_ctrl_sva chk_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
  .paddr, .pwdata, .irq_service_start, .ext_int_n, .supply_ok, .strobe_out,
  .strobe_weak, .clk_gate, .sys_reset, .fetch_addr, .port_latch_ones,
  .flash_cmd_valid, .flash_cmd);

// ===== rplc_partner.sv
// Model of the outside: reset circuit and clock gating hardware.
// Assumes the bench requests both in the pclk domain.
`timescale 1ns/100ps
module rplc_partner #(
  parameter int HOLD_CLKS = 30 // Reset pin high time, 24 at least
) (
  // Clock
  input  wire logic pclk,
  // Bench requests
  input  wire logic rst_req,
  input  wire logic stop_req,
  // Pins toward the block
  output wire logic reset_pin,
  output logic      ce
);
  int cnt = 0; // Reset-high clocks left
  initial ce = 1'b1;
  // Stretch a request to the full hold time
  always @(posedge pclk) begin
    if (rst_req) cnt <= HOLD_CLKS;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  assign reset_pin = (cnt != 0);
  // Gate only on an edge, so no runt pulse
  always @(posedge pclk) ce <= !stop_req;
endmodule

// ===== tb_rplc_ctrl.sv
// Self-checking bench for rplc_ctrl.
// Assumes the partner model and the bound checker.
`timescale 1ns/100ps
module tb_rplc_ctrl;
  import rplc_pkg::*;
  // Stimulus, valued at time zero except rdat and rerr
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, security_byte = 8'hff;
  logic [31:0] pwdata = 32'h0, rdat;
  logic external_access_n = 1'b1, ext_int_n = 1'b1, supply_ok = 1'b1, rerr;
  logic host_mode = 1'b0, chip_erase_done = 1'b0, irq_service_start = 1'b0;
  logic rst_req = 1'b0, stop_req = 1'b0;
  rplc_strobe_t cpu_strobe = 2'b01; // Distinct from idle and pd levels
  // Observed
  wire logic ce, reset_pin, pready, pslverr, strobe_weak, sys_reset;
  wire logic port_latch_ones, flash_cmd_valid;
  wire logic [31:0] prdata;
  wire logic [15:0] fetch_addr;
  rplc_strobe_t strobe_out;
  rplc_clkgate_t clk_gate;
  rplc_fcmd_t flash_cmd;
  int mismatches = 0, checks = 0;
  rplc_partner part_u (.pclk, .rst_req, .stop_req, .reset_pin, .ce);
  rplc_ctrl dut_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .reset_pin, .external_access_n, .ext_int_n, .supply_ok,
    .host_mode, .security_byte, .chip_erase_done, .irq_service_start, .cpu_strobe,
    .strobe_out, .strobe_weak, .clk_gate, .sys_reset, .fetch_addr, .port_latch_ones,
    .flash_cmd_valid, .flash_cmd);
  // ----
  // Shared tasks
  // ----
  task automatic finish_test;
    if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One APB transfer; an idle edge first keeps psel single-driven
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      finish_test();
    end
  endtask
  // Bounded wait for internal reset to reach a level
  task automatic wait_rst(input logic v, output int n);
    n = 0;
    while (sys_reset !== v && n < 40) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 40) begin
      mismatches++;
      finish_test();
    end
  endtask
  task automatic pin_reset;
    int n;
    @(posedge pclk);
    rst_req <= 1'b1;
    @(posedge pclk);
    rst_req <= 1'b0;
    wait_rst(1'b1, n);
    chk(n > 23, 1'b1);
    @(posedge pclk);
    chk({strobe_weak, port_latch_ones, strobe_out}, 4'hf);
    wait_rst(1'b0, n);
    repeat (3) @(posedge pclk);
  endtask
  function automatic logic allowed(int l, int b, int h, int ea);
    return l == 0 || (l == 1 && b == 0) || (l == 2 && h == 0 && ea == 1);
  endfunction
  // Issue one mailbox command and judge the sticky status bits
  task automatic cmd(input int c, input int b, input int h, input int ea, input logic e);
    host_mode <= h[0];
    external_access_n <= ea[0];
    repeat (3) @(posedge pclk);
    apb(1'b1, RPLC_MBOX_OFS, {23'h0, b[0], 4'h0, c[3:0]});
    apb(1'b0, RPLC_STAT_OFS, 32'h0);
    chk(rdat[5:4], {e, ~e});
    apb(1'b1, RPLC_STAT_OFS, 32'h30);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_lock;
    logic [3:0] sec [4] = '{4'hf, 4'h3, 4'h5, 4'ha};
    for (int i = 0; i < 4; i++) begin
      security_byte <= {4'h0, sec[i]};
      pin_reset();
      security_byte <= 8'hff; // Late change must not reach the lock
      apb(1'b0, RPLC_FCFG_OFS, 32'h0);
      chk(rdat[1:0], 2'h0);
      apb(1'b1, RPLC_FCFG_OFS, 32'h63);
      apb(1'b0, RPLC_FCFG_OFS, 32'h0);
      chk({rdat[6:5], rdat[1:0]}, {2'(i), 2'h3});
      for (int c = 2; c < 7; c++)
        for (int k = 0; k < 8; k++)
          cmd(c, k % 2, (k / 2) % 2, k / 4, allowed(i, k % 2, (k / 2) % 2, k / 4));
      cmd(1, 0, 1, 1, 1'b1);
      chip_erase_done <= 1'b1;
      @(posedge pclk);
      chip_erase_done <= 1'b0;
      apb(1'b0, RPLC_FCFG_OFS, 32'h0);
      chk(rdat[6:5], 2'h0);
    end
    supply_ok <= 1'b0;
    repeat (4) @(posedge pclk);
    cmd(1, 0, 0, 1, 1'b0);
    supply_ok <= 1'b1;
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
  endtask
  task automatic t_power;
    apb(1'b1, RPLC_POWER_CONTROL_REG_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    chk({clk_gate, strobe_out}, 5'h0f);
    irq_service_start <= 1'b1;
    @(posedge pclk);
    irq_service_start <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({clk_gate, strobe_out}, 5'h1d);
    apb(1'b1, RPLC_POWER_CONTROL_REG_OFS, 32'h3);
    repeat (2) @(posedge pclk);
    chk({clk_gate, strobe_out}, 5'h00);
    stop_req <= 1'b1;
    ext_int_n <= 1'b0;
    repeat (8) @(posedge pclk);
    chk({pready, clk_gate}, 4'h0);
    stop_req <= 1'b0;
    repeat (6) @(posedge pclk);
    ext_int_n <= 1'b1;
    chk(clk_gate, 3'h7);
  endtask
  // ----
  // Clock and main sequence
  // ----
  initial begin
    forever #2 pclk = ~pclk;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_lock();
    t_power();
    finish_test();
  end
endmodule
